// *** rtl/hdl_pkg.sv ***
// Constants for the host I/O decode and local bus DMA block
package hdl_pkg;
   localparam int          IO_AW            = 5;
   localparam logic [4:0]  IO_REG_LO        = 5'h00;
   localparam logic [4:0]  IO_REG_HI        = 5'h0F;
   localparam logic [4:0]  IO_DMA_LO        = 5'h10;
   localparam logic [4:0]  IO_DMA_HI        = 5'h17;
   localparam logic [4:0]  IO_RST_LO        = 5'h18;
   localparam logic [4:0]  IO_RST_HI        = 5'h1F;
   localparam logic [15:0] MEM_ID_LO        = 16'h0000;
   localparam logic [15:0] MEM_ID_HI        = 16'h001F;
   localparam logic [15:0] MEM_RAM_LO       = 16'h4000;
   localparam logic [15:0] MEM_RAM_HI       = 16'h7FFF;
   localparam int          ID_WORDS         = 3;
   localparam int          LDMA_BATCH_MAX   = 12;
   localparam int          CLK_PERIOD_PS    = 20000;
   localparam int          SOFT_RST_NS      = 780;
   localparam int          SOFT_RST_CYC     =
      (SOFT_RST_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [1:0]  PAGE_RESET       = 2'h0;

   typedef enum logic [3:0] {
      HDL_IDLE  = 4'h1,
      HDL_SLAVE = 4'h2,
      HDL_DMA   = 4'h4,
      HDL_HOST  = 4'h8
   } hdl_mode_e;
endpackage

// *** rtl/hdl_pulse_timer.sv ***
// Retriggerable fixed-length pulse generator
`timescale 1ns/1ps
module hdl_pulse_timer #(
   parameter int LEN = 39
) (
   input  wire logic clk_i,    // Clock
   input  wire logic rst_i,    // Synchronous reset
   input  wire logic start_i,  // Start pulse
   output logic      active_o  // High while running
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        act_reg;
   logic        act_next;

   always_comb begin
      cnt_next = cnt_reg;
      act_next = act_reg;
      if (start_i) begin
         cnt_next = 16'(LEN);
         act_next = 1'b1;
      end else if (cnt_reg > 16'h0001) begin
         cnt_next = cnt_reg - 16'h0001;
      end else begin
         cnt_next = 16'h0000;
         act_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 16'h0000;
         act_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         act_reg <= act_next;
      end
   end

   assign active_o = act_reg;
endmodule // hdl_pulse_timer

// *** rtl/hdl_bridge.sv ***
// Host I/O decode, remote/local DMA and local bus arbiter
//
// Summary of operation
// - I/O offsets 00h-0Fh go to the core registers as slave accesses.
// - I/O offsets 10h-17h are remote DMA data port transfers.
// - Read at 18h-1Fh pulses core soft reset for about 780 ns.
// - Buffer space: ID at 0000h-001Fh, RAM at 4000h-7FFFh, rest unused.
// - After power-on, station ID loaded from first three config words.
// - Arbiter starts idle; states are idle, slave, DMA, host.
// - Enter slave, DMA or host mode by request; one state at a time.
// - Simultaneous requests in idle: the host I/O request wins over local DMA.
// - Remote DMA only via host I/O; up to a double word per access.
// - Remote DMA waiting for bus holds target ready deasserted.
// - Byte counter decrements; stops at zero; short final reads.
// - Local DMA moves at most twelve bytes per bus tenure.
// - Local DMA acknowledged at once if bus free, else withheld.
// - Core checks FIFO thresholds after each batch to request again.
// - Local DMA needs no host; host does only remote DMA.
// - Command register page field selects the register page.
`timescale 1ns/1ps
module hdl_bridge
   import hdl_pkg::*;
#(
   parameter int RAM_AW = 14
) (
   input  wire logic        clk_i,          // Host bus clock
   input  wire logic        rst_i,          // Power-on reset
   input  wire logic        io_req_i,       // Host I/O cycle request
   input  wire logic        io_wr_i,        // 1 write, 0 read
   input  wire logic [4:0]  io_addr_i,      // Offset above I/O base
   input  wire logic [3:0]  io_be_i,        // Byte enables, high active
   input  wire logic [31:0] io_wdata_i,     // Write data
   output logic             io_trdy_o,      // Target ready pulse
   output logic [31:0]      io_rdata_o,     // Read data
   input  wire logic [7:0]  reg_rdata_i,    // Core register read data
   output logic             reg_stb_o,      // Core register strobe
   output logic             reg_wr_o,       // Core register write
   output logic [1:0]       reg_page_o,     // Selected register page
   output logic [3:0]       reg_idx_o,      // register_index_bits
   output logic [7:0]       reg_wdata_o,    // Core register write data
   output logic             core_rst_o,     // Soft reset to network core
   input  wire logic [15:0] rdma_addr_i,    // Remote start address
   input  wire logic [15:0] rdma_count_i,   // Remote byte count load
   input  wire logic        rdma_load_i,    // Load address and count
   output logic [15:0]      rdma_left_o,    // Remaining byte count
   input  wire logic        ldma_req_i,     // Local DMA bus request
   output logic             ldma_ack_o,     // Local DMA bus acknowledge
   input  wire logic        ldma_wr_i,      // Local DMA write to memory
   input  wire logic [15:0] ldma_addr_i,    // Local DMA address
   input  wire logic [7:0]  ldma_wdata_i,   // Local DMA write data
   output logic [7:0]       ldma_rdata_o,   // Local DMA read data
   output logic             ldma_done_o,    // Batch ended pulse
   input  wire logic        cfg_vld_i,      // Config word valid
   input  wire logic [15:0] cfg_word_i,     // Config word data
   output logic             cfg_rd_o,       // Config word read request
   output logic [1:0]       cfg_addr_o,     // Config word address
   output logic [3:0]       mode_o          // Arbiter state, one-hot
);
   //////////////////////////////////////////////////////////////////////
   localparam int RAM_D = 1 << RAM_AW;

   logic [7:0]  ram [RAM_D];
   logic [7:0]  id_mem [2*ID_WORDS];
   logic        rst_pipe;

   hdl_mode_e   mode_reg, mode_next;
   logic        trdy_reg, trdy_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        rstb_reg, rstb_next;
   logic        rwr_reg, rwr_next;
   logic [1:0]  page_reg, page_next;
   logic [3:0]  idx_reg, idx_next;
   logic [7:0]  rwd_reg, rwd_next;
   logic [15:0] raddr_reg, raddr_next;
   logic [15:0] rcnt_reg, rcnt_next;
   logic [1:0]  lane_reg, lane_next;
   logic        ack_reg, ack_next;
   logic [3:0]  beat_reg, beat_next;
   logic        ldone_reg, ldone_next;
   logic [7:0]  lrd_reg, lrd_next;
   logic        ram_we;
   logic [15:0] ram_wa;
   logic [7:0]  ram_wd;
   logic        crd_reg, crd_next;
   logic [1:0]  caddr_reg, caddr_next;
   logic        cdone_reg, cdone_next;
   logic        soft_go;
   logic        soft_act;

   //////////////////////////////////////////////////////////////////////
   // Buffer space read: ID, RAM or zero for unused
   function automatic logic [7:0] mem_rd(input logic [15:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a <= MEM_ID_HI) begin
         if (a[4:0] < 5'(2*ID_WORDS))
            v = id_mem[a[2:0]];
      end else if (a >= MEM_RAM_LO && a <= MEM_RAM_HI) begin
         v = ram[a[RAM_AW-1:0]];
      end
      return v;
   endfunction

   //////////////////////////////////////////////////////////////////////
   // Arbiter: in idle a host request wins over a core local DMA request
   always_comb begin
      mode_next  = mode_reg;
      trdy_next  = 1'b0;
      rdata_next = rdata_reg;
      rstb_next  = 1'b0;
      rwr_next   = 1'b0;
      page_next  = page_reg;
      idx_next   = idx_reg;
      rwd_next   = rwd_reg;
      raddr_next = raddr_reg;
      rcnt_next  = rcnt_reg;
      lane_next  = lane_reg;
      ack_next   = ack_reg;
      beat_next  = beat_reg;
      ldone_next = 1'b0;
      lrd_next   = lrd_reg;
      ram_we     = 1'b0;
      ram_wa     = 16'h0000;
      ram_wd     = 8'h00;
      soft_go    = 1'b0;
      if (rdma_load_i) begin
         raddr_next = rdma_addr_i;
         rcnt_next  = rdma_count_i;
      end
      case (mode_reg)
         HDL_IDLE: begin
            lane_next = 2'h0;
            if (io_req_i && !trdy_reg) begin
               if (io_addr_i <= IO_REG_HI) begin
                  mode_next = HDL_SLAVE;
                  // Index leads so core data is valid in slave cycle
                  idx_next  = io_addr_i[3:0];
               end else begin
                  mode_next = HDL_HOST;
               end
            end else if (ldma_req_i && !ldone_reg) begin
               mode_next = HDL_DMA;
               ack_next  = 1'b1;
               beat_next = 4'h0;
            end
         end
         HDL_SLAVE: begin
            rstb_next = 1'b1;
            rwr_next  = io_wr_i;
            idx_next  = io_addr_i[3:0];
            rwd_next  = io_wdata_i[7:0];
            if (io_wr_i && io_addr_i[3:0] == 4'h0)
               page_next = io_wdata_i[7:6];
            rdata_next = {24'h000000, reg_rdata_i};
            trdy_next  = 1'b1;
            mode_next  = HDL_IDLE;
         end
         HDL_HOST: begin
            if (io_addr_i >= IO_RST_LO) begin
               if (!io_wr_i)
                  soft_go = 1'b1;
               rdata_next = 32'h00000000;
               trdy_next  = 1'b1;
               mode_next  = HDL_IDLE;
            end else begin
               // One byte lane per cycle, trdy held low meanwhile
               if (io_be_i[lane_reg] && rcnt_reg != 16'h0000) begin
                  raddr_next = raddr_reg + 16'h0001;
                  rcnt_next  = rcnt_reg - 16'h0001;
                  if (io_wr_i) begin
                     ram_we = raddr_reg >= MEM_RAM_LO
                              && raddr_reg <= MEM_RAM_HI;
                     ram_wa = raddr_reg;
                     ram_wd = io_wdata_i[8*lane_reg +: 8];
                  end else begin
                     rdata_next[8*lane_reg +: 8] = mem_rd(raddr_reg);
                  end
               end else begin
                  rdata_next[8*lane_reg +: 8] = 8'h00;
               end
               lane_next = lane_reg + 2'h1;
               if (lane_reg == 2'h3) begin
                  trdy_next = 1'b1;
                  mode_next = HDL_IDLE;
               end
            end
         end
         HDL_DMA: begin
            if (ldma_req_i && beat_reg < 4'(LDMA_BATCH_MAX)) begin
               beat_next = beat_reg + 4'h1;
               if (ldma_wr_i) begin
                  ram_we = ldma_addr_i >= MEM_RAM_LO
                           && ldma_addr_i <= MEM_RAM_HI;
                  ram_wa = ldma_addr_i;
                  ram_wd = ldma_wdata_i;
               end else begin
                  lrd_next = mem_rd(ldma_addr_i);
               end
               // Last allowed beat closes the tenure itself
               if (beat_reg == 4'(LDMA_BATCH_MAX - 1)) begin
                  ack_next   = 1'b0;
                  ldone_next = 1'b1;
                  mode_next  = HDL_IDLE;
               end
            end else begin
               // Core rechecks thresholds before next request
               ack_next   = 1'b0;
               ldone_next = 1'b1;
               mode_next  = HDL_IDLE;
            end
         end
         default: mode_next = HDL_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg  <= HDL_IDLE;
         trdy_reg  <= 1'b0;
         rdata_reg <= 32'h00000000;
         rstb_reg  <= 1'b0;
         rwr_reg   <= 1'b0;
         page_reg  <= PAGE_RESET;
         idx_reg   <= 4'h0;
         rwd_reg   <= 8'h00;
         raddr_reg <= 16'h0000;
         rcnt_reg  <= 16'h0000;
         lane_reg  <= 2'h0;
         ack_reg   <= 1'b0;
         beat_reg  <= 4'h0;
         ldone_reg <= 1'b0;
         lrd_reg   <= 8'h00;
      end else begin
         mode_reg  <= mode_next;
         trdy_reg  <= trdy_next;
         rdata_reg <= rdata_next;
         rstb_reg  <= rstb_next;
         rwr_reg   <= rwr_next;
         page_reg  <= page_next;
         idx_reg   <= idx_next;
         rwd_reg   <= rwd_next;
         raddr_reg <= raddr_next;
         rcnt_reg  <= rcnt_next;
         lane_reg  <= lane_next;
         ack_reg   <= ack_next;
         beat_reg  <= beat_next;
         ldone_reg <= ldone_next;
         lrd_reg   <= lrd_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ram_we)
         ram[ram_wa[RAM_AW-1:0]] <= ram_wd;
   end

   //////////////////////////////////////////////////////////////////////
   // Station ID load after power-on
   always_comb begin
      crd_next   = crd_reg;
      caddr_next = caddr_reg;
      cdone_next = cdone_reg;
      if (!cdone_reg) begin
         crd_next = 1'b1;
         if (cfg_vld_i && crd_reg) begin
            if (caddr_reg == 2'(ID_WORDS - 1)) begin
               cdone_next = 1'b1;
               crd_next   = 1'b0;
            end
            caddr_next = caddr_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crd_reg   <= 1'b0;
         caddr_reg <= 2'h0;
         cdone_reg <= 1'b0;
      end else begin
         crd_reg   <= crd_next;
         caddr_reg <= caddr_next;
         cdone_reg <= cdone_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!cdone_reg && crd_reg && cfg_vld_i) begin
         id_mem[{caddr_reg, 1'b0}] <= cfg_word_i[7:0];
         id_mem[{caddr_reg, 1'b1}] <= cfg_word_i[15:8];
      end
   end

   //////////////////////////////////////////////////////////////////////
   hdl_pulse_timer #(
      .LEN (SOFT_RST_CYC)
   ) u_soft_rst (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (soft_go),
      .active_o (soft_act)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i)
         rst_pipe <= 1'b0;
      else
         rst_pipe <= soft_act;
   end

   assign io_trdy_o    = trdy_reg;
   assign io_rdata_o   = rdata_reg;
   assign reg_stb_o    = rstb_reg;
   assign reg_wr_o     = rwr_reg;
   assign reg_page_o   = page_reg;
   assign reg_idx_o    = idx_reg;
   assign reg_wdata_o  = rwd_reg;
   assign core_rst_o   = rst_pipe;
   assign rdma_left_o  = rcnt_reg;
   assign ldma_ack_o   = ack_reg;
   assign ldma_rdata_o = lrd_reg;
   assign ldma_done_o  = ldone_reg;
   assign cfg_rd_o     = crd_reg;
   assign cfg_addr_o   = caddr_reg;
   assign mode_o       = mode_reg;
endmodule // hdl_bridge

// *** verification/hdl_bridge_monitor.sv ***
// Concurrent checks on the bridge top-level ports
`timescale 1ns/1ps
module hdl_bridge_monitor
   import hdl_pkg::*;
(
   input wire logic        clk_i,       // Clock
   input wire logic        rst_i,       // Reset
   input wire logic        io_req_i,    // Host request
   input wire logic        io_wr_i,     // Host write
   input wire logic [4:0]  io_addr_i,   // Host offset
   input wire logic        io_trdy_o,   // Target ready
   input wire logic        reg_stb_o,   // Register strobe
   input wire logic [3:0]  reg_idx_o,   // Register index
   input wire logic        core_rst_o,  // Core soft reset
   input wire logic        ldma_req_i,  // Local DMA request
   input wire logic        ldma_ack_o,  // Local DMA acknowledge
   input wire logic        ldma_done_o, // Batch ended
   input wire logic [3:0]  mode_o       // Arbiter state
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] rst_cnt;
   logic [7:0] ack_cnt;
   always_ff @(posedge clk_i) begin
      rst_cnt <= (rst_i || !core_rst_o) ? 8'h00 : rst_cnt + 8'h01;
      ack_cnt <= (rst_i || !ldma_ack_o) ? 8'h00 : ack_cnt + 8'h01;
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_take;
      $rose(io_req_i) && mode_o == HDL_IDLE && !io_trdy_o;
   endsequence
   chk_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> mode_o == HDL_IDLE) else $error("mode not idle after reset");
   chk_mode_onehot: assert property ($onehot(mode_o))
      else $error("mode not one-hot");
   chk_reg_answer: assert property (s_take ##0 io_addr_i <= IO_REG_HI
      |-> ##2 (io_trdy_o && reg_stb_o)) else $error("register answer late");
   chk_dma_answer: assert property (s_take ##0 io_addr_i[4:3] == 2'b10
      |-> ##5 io_trdy_o) else $error("data port answer late");
   chk_reg_index: assert property (reg_stb_o |->
      io_addr_i <= IO_REG_HI && reg_idx_o == io_addr_i[3:0])
      else $error("register index wrong");
   chk_rst_cause: assert property ($rose(core_rst_o) |->
      !$past(io_wr_i) && $past(io_addr_i) >= IO_RST_LO)
      else $error("stray reset");
   chk_rst_length: assert property ($fell(core_rst_o) |->
      rst_cnt == SOFT_RST_CYC) else $error("soft reset length wrong");
   chk_dma_wait: assert property (io_req_i && mode_o == HDL_DMA
      |-> !io_trdy_o) else $error("ready during local DMA");
   chk_ack_held: assert property (mode_o == HDL_HOST |-> !ldma_ack_o)
      else $error("ack while host owns bus");
   chk_ldma_grant: assert property (ldma_req_i && !io_req_i &&
      mode_o == HDL_IDLE && !ldma_ack_o && !ldma_done_o |=> ldma_ack_o)
      else $error("free bus not granted");
   chk_batch_size: assert property (ack_cnt <= LDMA_BATCH_MAX)
      else $error("batch too long");
endmodule // hdl_bridge_monitor
bind hdl_bridge hdl_bridge_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .io_req_i(io_req_i), .io_wr_i(io_wr_i), .io_addr_i(io_addr_i),
   .io_trdy_o(io_trdy_o), .reg_stb_o(reg_stb_o), .reg_idx_o(reg_idx_o),
   .core_rst_o(core_rst_o), .ldma_req_i(ldma_req_i),
   .ldma_ack_o(ldma_ack_o), .ldma_done_o(ldma_done_o), .mode_o(mode_o));

// *** verification/hdl_far_model.sv ***
// Config memory and core register file seen by the bridge
`timescale 1ns/1ps
module hdl_far_model (
   input  wire logic       clk_i,     // Clock
   input  wire logic       rst_i,     // Reset
   input  wire logic       cfg_rd_i,  // Word request
   input  wire logic [1:0] cfg_addr_i,// Word address
   input  wire logic [3:0] reg_idx_i, // Register index
   output logic            cfg_vld_o, // Word valid pulse
   output logic [15:0]     cfg_word_o,// Word data
   output logic [7:0]      reg_rdata_o,// Register data
   output int              n_cfg_o    // Words served
);
   logic [2:0] wait_reg;
   assign reg_rdata_o = {4'hC, reg_idx_i};
   // Odd words answer slowly; data scrambles outside the valid pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_reg   <= 3'h0;
         cfg_vld_o  <= 1'b0;
         cfg_word_o <= 16'h0000;
         n_cfg_o    <= 0;
      end else begin
         cfg_vld_o  <= 1'b0;
         cfg_word_o <= ~cfg_word_o;
         if (wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
            if (wait_reg == 3'h1) begin
               cfg_vld_o  <= 1'b1;
               cfg_word_o <= {14'h2950, cfg_addr_i};
               n_cfg_o    <= n_cfg_o + 1;
            end
         end else if (cfg_rd_i && !cfg_vld_o) begin
            wait_reg <= cfg_addr_i[0] ? 3'h4 : 3'h1;
         end
      end
   end
endmodule // hdl_far_model

// *** verification/hdl_bridge_test.sv ***
// Self-checking bench for the host I/O bridge
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module hdl_bridge_test;
   import hdl_pkg::*;
   typedef struct {logic w; logic [4:0] a; logic [31:0] d;
      logic [7:0] r; logic [1:0] pg;} hdl_row_s;
   logic clk_i = 0, rst_i = 1, io_req_i = 0, io_wr_i = 0, rdma_load_i = 0;
   logic ldma_req_i = 0, ldma_wr_i = 0, cfg_vld_i, io_trdy_o, reg_stb_o;
   logic [4:0] io_addr_i = 0;
   logic [3:0] io_be_i = 4'hF, reg_idx_o, mode_o;
   logic [31:0] io_wdata_i = 0, io_rdata_o;
   logic [15:0] rdma_addr_i = 0, rdma_count_i = 0, rdma_left_o, cfg_word_i;
   logic [15:0] ldma_addr_i = 16'h4020;
   logic [7:0] ldma_wdata_i = 8'h5A, reg_rdata_i, ldma_rdata_o, reg_wdata_o;
   logic [1:0] reg_page_o, cfg_addr_o;
   int n_mismatch = 0, checks = 0, lat, k, n_cfg;
   logic cfg_rd_o, ldma_ack_o, ldma_done_o, core_rst_o, reg_wr_o;
   hdl_row_s rows[6] = '{'{1, 5'h00, 32'hC0, 8'h0, 2'h3},
      '{0, 5'h05, 0, 8'hC5, 2'h3}, '{0, 5'h0F, 0, 8'hCF, 2'h3},
      '{1, 5'h00, 32'h40, 8'h0, 2'h1}, '{0, 5'h00, 0, 8'hC0, 2'h1},
      '{1, 5'h07, 32'h11, 8'h0, 2'h1}};
   hdl_bridge u_hdl_bridge (.clk_i(clk_i), .rst_i(rst_i),
      .io_req_i(io_req_i), .io_wr_i(io_wr_i), .io_addr_i(io_addr_i),
      .io_be_i(io_be_i), .io_wdata_i(io_wdata_i), .io_trdy_o(io_trdy_o),
      .io_rdata_o(io_rdata_o), .reg_rdata_i(reg_rdata_i),
      .reg_stb_o(reg_stb_o), .reg_wr_o(reg_wr_o), .reg_page_o(reg_page_o),
      .reg_idx_o(reg_idx_o), .reg_wdata_o(reg_wdata_o),
      .core_rst_o(core_rst_o), .rdma_addr_i(rdma_addr_i),
      .rdma_count_i(rdma_count_i), .rdma_load_i(rdma_load_i),
      .rdma_left_o(rdma_left_o), .ldma_req_i(ldma_req_i),
      .ldma_ack_o(ldma_ack_o), .ldma_wr_i(ldma_wr_i),
      .ldma_addr_i(ldma_addr_i), .ldma_wdata_i(ldma_wdata_i),
      .ldma_rdata_o(ldma_rdata_o), .ldma_done_o(ldma_done_o),
      .cfg_vld_i(cfg_vld_i), .cfg_word_i(cfg_word_i), .cfg_rd_o(cfg_rd_o),
      .cfg_addr_o(cfg_addr_o), .mode_o(mode_o));
   hdl_far_model u_hdl_far_model (.clk_i(clk_i), .rst_i(rst_i),
      .cfg_rd_i(cfg_rd_o), .cfg_addr_i(cfg_addr_o),
      .reg_idx_i(reg_idx_o), .cfg_vld_o(cfg_vld_i), .cfg_word_o(cfg_word_i),
      .reg_rdata_o(reg_rdata_i), .n_cfg_o(n_cfg));
   ////////////////////////////////////////////////////////////////////////
   task automatic io(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      io_req_i <= 1; io_wr_i <= w; io_addr_i <= a; io_wdata_i <= d;
      lat = 0;
      do begin @(posedge clk_i); lat++; end
      while (io_trdy_o !== 1'b1 && lat < 200);
      io_req_i <= 0;
   endtask
   task automatic ld(input logic [15:0] a, input logic [15:0] c);
      @(posedge clk_i);
      rdma_addr_i <= a; rdma_count_i <= c; rdma_load_i <= 1;
      @(posedge clk_i);
      rdma_load_i <= 0;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial forever #10 clk_i = ~clk_i;
   initial begin
      repeat (6000) @(posedge clk_i);
      n_mismatch++;
      final_report;
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      `CHK(mode_o, HDL_IDLE)
      repeat (40) @(posedge clk_i);
      `CHK(n_cfg, ID_WORDS)
      `CHK(cfg_rd_o, 1'b0)
      ld(16'h0000, 16'd8); io(0, 5'h10, 0);
      `CHK(io_rdata_o, 32'hA541A540)
      io(0, 5'h10, 0); `CHK(io_rdata_o, 32'h0000A542)
      foreach (rows[i]) begin
         io(rows[i].w, rows[i].a, rows[i].d);
         `CHK(lat, 3)
         `CHK(reg_wr_o, rows[i].w)
         `CHK(reg_idx_o, rows[i].a[3:0])
         if (rows[i].w) `CHK(reg_wdata_o, rows[i].d[7:0])
         if (!rows[i].w) `CHK(io_rdata_o[7:0], rows[i].r)
         `CHK(reg_page_o, rows[i].pg)
      end
      // Host copies a frame in first, then reads it back
      ld(16'h4000, 16'd8); io(1, 5'h10, 32'h44332211);
      `CHK(lat, 6)
      io(1, 5'h17, 32'h88776655); `CHK(rdma_left_o, 16'h0)
      ld(16'h4004, 16'd8); io(0, 5'h14, 0);
      `CHK(io_rdata_o, 32'h88776655)
      `CHK(rdma_left_o, 16'h4)
      ld(16'h4000, 16'd3); io(0, 5'h10, 0);
      `CHK(io_rdata_o, 32'h00332211)
      io(0, 5'h10, 0); `CHK(io_rdata_o, 32'h0)
      ld(16'h8000, 16'd4); io(0, 5'h10, 0); `CHK(io_rdata_o, 32'h0)
      ld(16'h4000, 16'd4); io_be_i <= 4'h3; io(0, 5'h10, 0);
      `CHK(io_rdata_o, 32'h00002211)
      `CHK(rdma_left_o, 16'h2)
      io_be_i <= 4'hF;
      for (int j = 0; j < 3; j++) begin
         io(j == 2, j == 1 ? 5'h1F : 5'h18, 0);
         `CHK(lat, 3)
         k = 0;
         repeat (60) begin @(posedge clk_i); if (core_rst_o === 1'b1) k++; end
         `CHK(k, j == 2 ? 0 : SOFT_RST_CYC)
      end
      ldma_req_i <= 1; ldma_wr_i <= 1; k = 0; lat = 0;
      repeat (30) begin
         @(posedge clk_i);
         if (ldma_ack_o === 1'b1) k++;
         if (ldma_done_o === 1'b1 && lat == 0) begin
            lat = 1; ldma_req_i <= 0;
         end
      end
      `CHK(lat, 1)
      `CHK(k inside {[1:LDMA_BATCH_MAX]}, 1'b1)
      ld(16'h4020, 16'd1); io(0, 5'h10, 0); `CHK(io_rdata_o, 32'h5A)
      ld(16'h4020, 16'd1);
      ldma_req_i <= 1; ldma_wr_i <= 0;
      repeat (2) @(posedge clk_i);
      `CHK(ldma_ack_o, 1'b1)
      io(0, 5'h10, 0);
      `CHK(lat > 6, 1'b1)
      `CHK(io_rdata_o, 32'h5A)
      `CHK(ldma_rdata_o, 8'h5A)
      ldma_req_i <= 0;
      repeat (20) @(posedge clk_i);
      // Reset again in mid-run: state clears, station ID reloads
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      `CHK(mode_o, HDL_IDLE)
      `CHK(io_rdata_o, 32'h0)
      `CHK(reg_page_o, PAGE_RESET)
      repeat (20) @(posedge clk_i);
      `CHK(n_cfg, ID_WORDS)
      final_report;
   end
endmodule // hdl_bridge_test
